// ===== bench/peripheral_port_config_tb.sv
/* Self-checking bench for the port configuration bank.
   Drives all inputs itself; the checker is bound at the foot. */
`timescale 1ns/1ps
`include "port_cfg_map.svh"
module peripheral_port_config_tb;
	import port_cfg_pkg::*;
	typedef struct {string what; logic [15:0] val;} note_s;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	cfg_byte_t regAddr = 8'h00;
	cfg_byte_t regWrData = 8'h00;
	cfg_byte_t regRdData;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic strapParDisable = 1'b1;
	logic strapSerDisable = 1'b0;
	logic strapSerPowerDown = 1'b1;
	logic secondFddPresent = 1'b0;
	io_addr_t ioAddr = 10'h000;
	logic ioStrobe = 1'b0;
	logic parIrqReq = 1'b0;
	logic serIrqReqA = 1'b0;
	logic serIrqReqB = 1'b0;
	logic baudTickIn = 1'b0;
	logic parAddrHit, parallel_irq_out, parallelIrqOe, serial_irq_out_a, serialIrqOeA;
	logic serial_irq_out_b, serialIrqOeB, baudTickOut, ecpEnable, parEnable, parPowerDown;
	logic fdcRedirect, serEnableA, serPowerDownA, serEnableB, serPowerDownB;
	logic [15:0] outVec;
	logic [15:0] got;
	logic rdPend = 1'b0;
	logic probeOn = 1'b0;
	note_s cur;
	note_s notes[$];
	cfg_byte_t be = 8'hD0;
	cfg_byte_t bf = 8'h9E;
	cfg_byte_t db = 8'hC8;
	cfg_byte_t a;
	cfg_byte_t regs[3] = '{`PCFG_PAR_CTRL_IDX, `PCFG_PAR_BASE_IDX, `PCFG_SER_CTRL_IDX};
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;

	peripheral_port_config peripheral_port_config_i (.*);

	assign outVec = {parAddrHit, parallel_irq_out, parallelIrqOe, serial_irq_out_a, serialIrqOeA, serial_irq_out_b,
		serialIrqOeB, baudTickOut, ecpEnable, parEnable, parPowerDown, fdcRedirect, serEnableA, serPowerDownA,
		serEnableB, serPowerDownB};
	////////////////////////////////////////////////////////////
	// Expected outputs from the shadow registers
	function automatic logic [15:0] expOut(io_addr_t ad, logic [2:0] rq, logic tk);
		expOut = {ad[9:2] == bf && !be[4], rq[2] ~^ be[7], !be[4], rq[1] ~^ db[6], !db[4],
			rq[0] ~^ db[7], !db[1], tk && !db[5], !be[6], !be[4], be[3], be[2], !db[4], db[3], !db[1], db[0]};
	endfunction : expOut

	function automatic cfg_byte_t regExp(cfg_byte_t ad);
		regExp = ad == `PCFG_PAR_CTRL_IDX ? be | {6'h00, secondFddPresent, 1'b0} :
			ad == `PCFG_PAR_BASE_IDX ? bf : ad == `PCFG_SER_CTRL_IDX ? db : 8'h00;
	endfunction : regExp

	task automatic wr(cfg_byte_t ad, cfg_byte_t d);
		regAddr <= ad;
		regWrData <= d;
		regWrite <= 1'b1;
		if (ad == `PCFG_PAR_CTRL_IDX) be = (be & ~`PCFG_PAR_CTRL_WMASK) | (d & `PCFG_PAR_CTRL_WMASK);
		if (ad == `PCFG_PAR_BASE_IDX) bf = d;
		if (ad == `PCFG_SER_CTRL_IDX) db = (db & ~`PCFG_SER_CTRL_WMASK) | (d & `PCFG_SER_CTRL_WMASK);
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(cfg_byte_t ad);
		notes.push_back('{"read data", {8'h00, regExp(ad)}});
		regAddr <= ad;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
	endtask : rd

	// Strobe one I/O cycle; every output but regRdData is looked at in the next cycle
	task automatic probe(io_addr_t ad, logic [2:0] rq, logic tk);
		notes.push_back('{"port outputs", expOut(ad, rq, tk)});
		ioAddr <= ad;
		ioStrobe <= 1'b1;
		{parIrqReq, serIrqReqA, serIrqReqB} <= rq;
		baudTickIn <= tk;
		@(posedge sys_clk);
		ioStrobe <= 1'b0;
		probeOn <= 1'b1;
		@(posedge sys_clk);
		probeOn <= 1'b0;
	endtask : probe

	task automatic complete_run();
		if (mismatches == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////
	// Clock, and a ceiling far above the roughly 180 cycles needed
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			complete_run();
		end
	end
	// Oldest note against whatever result appears
	always @(posedge sys_clk) begin
		rdPend <= regRead;
		if (rdPend || probeOn) begin
			cur = notes.pop_front();
			got = rdPend ? {8'h00, regRdData} : outVec;
			checks_done++;
			if (got !== cur.val) begin
				mismatches++;
				$display("wrong value %s expected %h seen %h", cur.what, cur.val, got);
			end
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h6e31));
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (3) @(posedge sys_clk);
		// Reset values, straps, disabled decode
		foreach (regs[i]) begin
			rd(regs[i]);
			probe(10'h278, 3'b000, 1'b1);
		end
		// All ones then all zeros: masks, reserved bits, enable again
		foreach (regs[i]) begin
			wr(regs[i], 8'hFF);
			rd(regs[i]);
			probe({bf, 2'b01}, 3'b111, 1'b1);
			wr(regs[i], 8'h00);
			rd(regs[i]);
			probe({bf, 2'b10}, 3'b101, 1'b1);
		end
		wr(8'h7E, 8'hFF);
		rd(8'h7E);
		secondFddPresent <= 1'b1;
		@(posedge sys_clk);
		wr(`PCFG_PAR_CTRL_IDX, 8'h00);
		rd(`PCFG_PAR_CTRL_IDX);
		// Random settings, back-to-back readback and decode
		repeat (30) begin
			a = regs[$urandom_range(2)];
			wr(a, 8'($urandom));
			rd(a);
			probe($urandom_range(1) ? {bf, 2'($urandom)} : 10'($urandom), 3'($urandom), 1'($urandom));
		end
		// Second reset with the straps turned over; requests quiet first
		reset <= 1'b1;
		{strapParDisable, strapSerDisable, strapSerPowerDown} <= 3'b010;
		{parIrqReq, serIrqReqA, serIrqReqB} <= 3'b000;
		baudTickIn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		be = 8'hC0;
		bf = 8'h9E;
		db = 8'hD0;
		repeat (3) @(posedge sys_clk);
		foreach (regs[i]) begin
			rd(regs[i]);
			probe(10'h278, 3'b010, 1'b1);
		end
		repeat (3) @(posedge sys_clk);
		complete_run();
	end
endmodule : peripheral_port_config_tb

bind peripheral_port_config ppc_props ppc_props_i (.*);

// ===== bench/ppc_props.sv
/* Checker for the port configuration bank.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
`include "port_cfg_map.svh"
module ppc_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port
	input wire port_cfg_pkg::cfg_byte_t regAddr,
	input wire port_cfg_pkg::cfg_byte_t regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire port_cfg_pkg::cfg_byte_t regRdData,
	// Decode, pins and controls
	input wire port_cfg_pkg::io_addr_t ioAddr,
	input wire logic ioStrobe,
	input wire logic parAddrHit,
	input wire logic parIrqReq,
	input wire logic parallel_irq_out,
	input wire logic baudTickIn,
	input wire logic baudTickOut,
	input wire logic ecpEnable,
	input wire logic parEnable,
	input wire logic parPowerDown,
	input wire logic fdcRedirect
);
	import port_cfg_pkg::*;
	cfg_byte_t beQ;
	cfg_byte_t bfQ;
	logic gateQ;
	logic mapped;
	////////////////////////////////////////////////////////////
	// Shadow of the bits that carry no strap value
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			beQ <= `PCFG_PAR_CTRL_RST;
			bfQ <= `PCFG_PAR_BASE_RST;
			gateQ <= 1'b0;
		end else if (regWrite) begin
			if (regAddr == `PCFG_PAR_CTRL_IDX) beQ <= regWrData;
			if (regAddr == `PCFG_PAR_BASE_IDX) bfQ <= regWrData;
			if (regAddr == `PCFG_SER_CTRL_IDX) gateQ <= regWrData[5];
		end
	end
	// Index decode
	assign mapped = regAddr inside {`PCFG_PAR_CTRL_IDX, `PCFG_PAR_BASE_IDX, `PCFG_SER_CTRL_IDX};
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Write then read of the base register
	sequence wrBase;
		regWrite && regAddr == `PCFG_PAR_BASE_IDX;
	endsequence
	sequence rdBase;
		regRead && regAddr == `PCFG_PAR_BASE_IDX;
	endsequence
	property baseBack;
		cfg_byte_t v;
		(wrBase, v = regWrData) ##1 rdBase |=> regRdData == v;
	endproperty
	a_read_gap: assert property (!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property ($past(regRead) && !$past(mapped) |-> regRdData == 8'h00)
		else $error("unmapped index read nonzero");
	a_reserved_zero: assert property ($past(regRead) && $past(regAddr) == `PCFG_PAR_CTRL_IDX
		|-> regRdData[5] == 1'b0 && regRdData[0] == 1'b0) else $error("reserved bit read one");
	a_base_readback: assert property (baseBack)
		else $error("base register lost written value");
	// The enable output is registered beside the hit, so both share one edge
	a_hit_decode: assert property ($past(ioStrobe) && parEnable
		|-> parAddrHit == ($past(ioAddr[9:2]) == $past(bfQ))) else $error("decode wrong");
	a_no_hit_off: assert property (!$past(ioStrobe) || !parEnable |-> !parAddrHit)
		else $error("hit while idle or disabled");
	a_pin_polarity: assert property (parallel_irq_out == ($past(parIrqReq) ~^ $past(beQ[7])))
		else $error("parallel pin polarity wrong");
	a_bank_controls: assert property ({ecpEnable, parPowerDown, fdcRedirect}
		== {!$past(beQ[6]), $past(beQ[3]), $past(beQ[2])}) else $error("parallel controls wrong");
	a_baud_gate: assert property (baudTickOut == ($past(baudTickIn) && !$past(gateQ)))
		else $error("baud tick gating wrong");
endmodule : ppc_props

// ===== common/irq_pin_if.sv
/*
 * Carrier between the configuration bank and one interrupt pin driver.
 * Assumes the driver samples everything on the system clock.
 */
`timescale 1ns/1ps

interface irq_pin_if;
	logic req;
	logic activeHigh;
	logic enable;
	logic pinOut;
	logic pinOe;

	modport drv (input req, input activeHigh, input enable, output pinOut, output pinOe);
	modport ctl (output req, output activeHigh, output enable, input pinOut, input pinOe);
endinterface : irq_pin_if

// ===== common/port_cfg_map.svh
/*
 * Register indices, field positions, reset values and write masks
 * of the peripheral port configuration bank.
 * Assumes an 8-bit index space reached through the register port.
 */
`ifndef PORT_CFG_MAP_SVH
`define PORT_CFG_MAP_SVH

// Register indices
`define PCFG_PAR_CTRL_IDX 8'hBE
`define PCFG_PAR_BASE_IDX 8'hBF
`define PCFG_SER_CTRL_IDX 8'hDB

// Parallel port control fields
`define PCFG_PAR_IRQ_POL_BIT 7
`define PCFG_ECP_OFF_BIT 6
`define PCFG_PAR_DIS_BIT 4
`define PCFG_PAR_PD_BIT 3
`define PCFG_FDC_REDIR_BIT 2
`define PCFG_FDD2_BIT 1

// Serial port control fields
`define PCFG_SERB_POL_BIT 7
`define PCFG_SERA_POL_BIT 6
`define PCFG_BAUD_GATE_BIT 5
`define PCFG_SERA_DIS_BIT 4
`define PCFG_SERA_PD_BIT 3
`define PCFG_SERB_DIS_BIT 1
`define PCFG_SERB_PD_BIT 0

// Reset values, strap-loaded bits excluded
`define PCFG_PAR_CTRL_RST 8'hC0
`define PCFG_PAR_BASE_RST 8'h9E
`define PCFG_SER_CTRL_RST 8'hC0

// Bits software may change
`define PCFG_PAR_CTRL_WMASK 8'hDC
`define PCFG_PAR_BASE_WMASK 8'hFF
`define PCFG_SER_CTRL_WMASK 8'hFB

`endif

// ===== common/port_cfg_pkg.sv
/*
 * Types shared by the peripheral port configuration design.
 * Assumes the constants header is compiled alongside.
 */
package port_cfg_pkg;

	typedef logic [7:0] cfg_byte_t;
	typedef logic [9:0] io_addr_t;

	// Start-up phase: straps are caught once, then normal running
	typedef enum logic {
		PH_STRAP = 1'b0,
		PH_RUN = 1'b1
	} cfg_phase_e;

endpackage : port_cfg_pkg

// ===== rtl/io_addr_match.sv
/*
 * Compares an I/O address against a programmed base on A9..A2.
 * Assumes address and strobe are synchronous to sys_clk.
 */
`timescale 1ns/1ps

module io_addr_match (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Address in
	input wire port_cfg_pkg::io_addr_t ioAddr,
	input wire logic ioStrobe,
	// Settings
	input wire port_cfg_pkg::cfg_byte_t baseAddr,
	input wire logic enable,
	// Result
	output logic hit_q
);
	import port_cfg_pkg::*;

	logic hitNow;

	// Four-byte window, nothing decoded while disabled
	assign hitNow = ioStrobe & enable & (ioAddr[9:2] == baseAddr);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= hitNow;
		end
	end
endmodule : io_addr_match

// ===== rtl/irq_pin_drive.sv
/*
 * Drives one interrupt pin with programmable polarity.
 * Assumes the request is synchronous to sys_clk.
 */
`timescale 1ns/1ps

module irq_pin_drive (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Pin control
	irq_pin_if.drv pin
);
	// Level follows polarity; pin released while its port is off
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin.pinOut <= 1'b0;
			pin.pinOe <= 1'b0;
		end else begin
			pin.pinOut <= pin.activeHigh ? pin.req : ~pin.req;
			pin.pinOe <= pin.enable;
		end
	end
endmodule : irq_pin_drive

// ===== rtl/peripheral_port_config.sv
/*
 * Configuration bank for the parallel and serial peripheral ports:
 * interrupt polarity, ECP enable, port disable and power-down,
 * parallel base decode, floppy redirect and baud clock gating.
 * Assumes one 125 MHz clock, all inputs synchronous to it, and a
 * register port with read data one cycle after the read strobe.
 */
// Chosen here: the address-and-strobe port.
// Functional notes
// - Three interrupt polarity bits, one means high
// - ECP bit zero enables, resets disabled
// - Parallel disable bit, power-up from strap
// - Parallel power-down bit, resets to zero
// - Floppy redirect to parallel pins, resets off
// - Second floppy status bit, read-only, resets zero
// - Parallel base A9..A2, resets to 9E
// - Baud clock gate, one stops, resets zero
// - Primary serial disable, power-up from strap
// - Primary serial power-down, power-up from strap
// - Secondary serial disable, power-down, reset zero
`timescale 1ns/1ps
`include "port_cfg_map.svh"

module peripheral_port_config (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port
	input wire port_cfg_pkg::cfg_byte_t regAddr,
	input wire port_cfg_pkg::cfg_byte_t regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output port_cfg_pkg::cfg_byte_t regRdData,
	// Power-up straps
	input wire logic strapParDisable,
	input wire logic strapSerDisable,
	input wire logic strapSerPowerDown,
	// Status from the floppy logic
	input wire logic secondFddPresent,
	// I/O decode
	input wire port_cfg_pkg::io_addr_t ioAddr,
	input wire logic ioStrobe,
	output logic parAddrHit,
	// Interrupt requests from the ports
	input wire logic parIrqReq,
	input wire logic serIrqReqA,
	input wire logic serIrqReqB,
	// Interrupt pins
	output logic parallel_irq_out,
	output logic parallelIrqOe,
	output logic serial_irq_out_a,
	output logic serialIrqOeA,
	output logic serial_irq_out_b,
	output logic serialIrqOeB,
	// Baud clock enable
	input wire logic baudTickIn,
	output logic baudTickOut,
	// Parallel port controls
	output logic ecpEnable,
	output logic parEnable,
	output logic parPowerDown,
	output logic fdcRedirect,
	// Serial port controls
	output logic serEnableA,
	output logic serPowerDownA,
	output logic serEnableB,
	output logic serPowerDownB
);
	import port_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Helpers
	// Keeps read-only and reserved bits, takes writable ones
	function automatic cfg_byte_t mergeWrite(
		input cfg_byte_t oldVal,
		input cfg_byte_t newVal,
		input cfg_byte_t wrMask
	);
		mergeWrite = (oldVal & ~wrMask) | (newVal & wrMask);
	endfunction : mergeWrite

	////////////////////////////////////////////////////////////////////
	// Declarations
	cfg_phase_e phase_q;
	cfg_phase_e phase_d;
	cfg_byte_t parCtrl_q;
	cfg_byte_t parCtrl_d;
	cfg_byte_t parBase_q;
	cfg_byte_t parBase_d;
	cfg_byte_t serCtrl_q;
	cfg_byte_t serCtrl_d;
	cfg_byte_t rdData_q;
	cfg_byte_t rdData_d;
	logic fdd2_q;
	logic baudTick_q;
	logic ecp_q;
	logic parEn_q;
	logic parPd_q;
	logic redir_q;
	logic serEnA_q;
	logic serPdA_q;
	logic serEnB_q;
	logic serPdB_q;

	logic selParCtrl;
	logic selParBase;
	logic selSerCtrl;
	logic wrParCtrl;
	logic wrParBase;
	logic wrSerCtrl;
	logic loadStraps;
	cfg_byte_t parCtrlView;
	cfg_byte_t rdMux;

	logic parOn;
	logic serOnA;
	logic serOnB;

	irq_pin_if parPin ();
	irq_pin_if serPinA ();
	irq_pin_if serPinB ();

	////////////////////////////////////////////////////////////////////
	// Address decode
	// Index selects for the three registers
	assign selParCtrl = (regAddr == `PCFG_PAR_CTRL_IDX);
	assign selParBase = (regAddr == `PCFG_PAR_BASE_IDX);
	assign selSerCtrl = (regAddr == `PCFG_SER_CTRL_IDX);

	// Write enables; writes elsewhere are dropped
	assign wrParCtrl = regWrite & selParCtrl;
	assign wrParBase = regWrite & selParBase;
	assign wrSerCtrl = regWrite & selSerCtrl;

	// Straps are caught once, on the first edge after release
	assign loadStraps = (phase_q == PH_STRAP);

	////////////////////////////////////////////////////////////////////
	// Start-up phase
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			PH_STRAP: phase_d = PH_RUN;
			PH_RUN: phase_d = PH_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			phase_q <= PH_STRAP;
		end else begin
			phase_q <= phase_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Parallel port control register
	// Strap load overrides a write landing on the same edge
	always_comb begin
		parCtrl_d = parCtrl_q;
		if (wrParCtrl) begin
			parCtrl_d = mergeWrite(parCtrl_q, regWrData, `PCFG_PAR_CTRL_WMASK);
		end
		if (loadStraps) begin
			parCtrl_d[`PCFG_PAR_DIS_BIT] = strapParDisable;
		end
	end

	// Polarity and ECP-off set, disable bit clear; port held off until straps land
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			parCtrl_q <= `PCFG_PAR_CTRL_RST;
		end else begin
			parCtrl_q <= parCtrl_d;
		end
	end

	// Second-drive status tracks the floppy logic, never software
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			fdd2_q <= 1'b0;
		end else begin
			fdd2_q <= secondFddPresent;
		end
	end

	// Read view: stored bits plus live status, reserved bits zero
	always_comb begin
		parCtrlView = parCtrl_q & `PCFG_PAR_CTRL_WMASK;
		parCtrlView[`PCFG_FDD2_BIT] = fdd2_q;
	end

	////////////////////////////////////////////////////////////////////
	// Parallel base address register
	always_comb begin
		parBase_d = parBase_q;
		if (wrParBase) begin
			parBase_d = mergeWrite(parBase_q, regWrData, `PCFG_PAR_BASE_WMASK);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			parBase_q <= `PCFG_PAR_BASE_RST;
		end else begin
			parBase_q <= parBase_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial port control register
	// Both primary serial bits take their straps once
	always_comb begin
		serCtrl_d = serCtrl_q;
		if (wrSerCtrl) begin
			serCtrl_d = mergeWrite(serCtrl_q, regWrData, `PCFG_SER_CTRL_WMASK);
		end
		if (loadStraps) begin
			serCtrl_d[`PCFG_SERA_DIS_BIT] = strapSerDisable;
			serCtrl_d[`PCFG_SERA_PD_BIT] = strapSerPowerDown;
		end
	end

	// Polarity bits set, gate open, secondary port on
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			serCtrl_q <= `PCFG_SER_CTRL_RST;
		end else begin
			serCtrl_q <= serCtrl_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path
	// Unmapped indices read as zero
	assign rdMux = selParCtrl ? parCtrlView :
		selParBase ? parBase_q :
		selSerCtrl ? (serCtrl_q & `PCFG_SER_CTRL_WMASK) :
		8'h00;

	// Data stands only in the cycle after the strobe
	assign rdData_d = regRead ? rdMux : 8'h00;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= rdData_d;
		end
	end

	assign regRdData = rdData_q;

	////////////////////////////////////////////////////////////////////
	// Port enables
	// Disable bits active high; parallel and primary serial off until straps land, so no stray drive
	assign parOn = ~parCtrl_q[`PCFG_PAR_DIS_BIT] & ~loadStraps;
	assign serOnA = ~serCtrl_q[`PCFG_SERA_DIS_BIT] & ~loadStraps;
	assign serOnB = ~serCtrl_q[`PCFG_SERB_DIS_BIT];

	////////////////////////////////////////////////////////////////////
	// Parallel address decode

	// A disabled port answers no I/O cycle; its base stays stored
	io_addr_match u_parDecode (
		.sys_clk(sys_clk),
		.reset(reset),
		.ioAddr(ioAddr),
		.ioStrobe(ioStrobe),
		.baseAddr(parBase_q),
		.enable(parOn),
		.hit_q(parAddrHit)
	);

	////////////////////////////////////////////////////////////////////
	// Interrupt pins

	// Pin released, not driven, while its port is off
	assign parPin.req = parIrqReq;
	assign parPin.activeHigh = parCtrl_q[`PCFG_PAR_IRQ_POL_BIT];
	assign parPin.enable = parOn;

	assign serPinA.req = serIrqReqA;
	assign serPinA.activeHigh = serCtrl_q[`PCFG_SERA_POL_BIT];
	assign serPinA.enable = serOnA;

	assign serPinB.req = serIrqReqB;
	assign serPinB.activeHigh = serCtrl_q[`PCFG_SERB_POL_BIT];
	assign serPinB.enable = serOnB;

	irq_pin_drive u_parIrq (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin(parPin)
	);

	irq_pin_drive u_serIrqA (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin(serPinA)
	);

	irq_pin_drive u_serIrqB (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin(serPinB)
	);

	assign parallel_irq_out = parPin.pinOut;
	assign parallelIrqOe = parPin.pinOe;
	assign serial_irq_out_a = serPinA.pinOut;
	assign serialIrqOeA = serPinA.pinOe;
	assign serial_irq_out_b = serPinB.pinOut;
	assign serialIrqOeB = serPinB.pinOe;

	////////////////////////////////////////////////////////////////////
	// Baud clock gate

	// Gating the enable, not the clock, keeps one clock tree
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			baudTick_q <= 1'b0;
		end else begin
			baudTick_q <= baudTickIn & ~serCtrl_q[`PCFG_BAUD_GATE_BIT];
		end
	end

	assign baudTickOut = baudTick_q;

	////////////////////////////////////////////////////////////////////
	// Control outputs

	// Registered copies so every output leaves a flip-flop
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ecp_q <= 1'b0;
			parEn_q <= 1'b0;
			parPd_q <= 1'b0;
			redir_q <= 1'b0;
			serEnA_q <= 1'b0;
			serPdA_q <= 1'b0;
			serEnB_q <= 1'b0;
			serPdB_q <= 1'b0;
		end else begin
			ecp_q <= ~parCtrl_q[`PCFG_ECP_OFF_BIT];
			parEn_q <= parOn;
			parPd_q <= parCtrl_q[`PCFG_PAR_PD_BIT];
			redir_q <= parCtrl_q[`PCFG_FDC_REDIR_BIT];
			serEnA_q <= serOnA;
			serPdA_q <= serCtrl_q[`PCFG_SERA_PD_BIT];
			serEnB_q <= serOnB;
			serPdB_q <= serCtrl_q[`PCFG_SERB_PD_BIT];
		end
	end

	assign ecpEnable = ecp_q;
	assign parEnable = parEn_q;
	assign parPowerDown = parPd_q;
	assign fdcRedirect = redir_q;
	assign serEnableA = serEnA_q;
	assign serPowerDownA = serPdA_q;
	assign serEnableB = serEnB_q;
	assign serPowerDownB = serPdB_q;

endmodule : peripheral_port_config
